//--- flash_sp_regs.svh
`ifndef FLASH_SP_REGS_SVH
`define FLASH_SP_REGS_SVH

`define CTRL_OFS      8'h00
`define PTR_OFS       8'h04
`define DATA_OFS      8'h08
`define INSTR_OFS     8'h0c
`define RDBK_OFS      8'h10
`define STATUS_OFS    8'h14

`define CTRL_IE       7
`define CTRL_BUSY     6
`define CTRL_REEN     4
`define CTRL_LOCK     3
`define CTRL_WR       2
`define CTRL_ER       1
`define CTRL_EN       0
`define INSTR_STORE   0
`define INSTR_LOAD    1

`define PAGE_HI       13
`define PAGE_LO       7
`define WORD_HI       6
`define WORD_LO       1
`define NO_READ_WHILE_WRITE_AREA_PAGE     7'h70

`define STORE_WIN     3'h4
`define LOAD_WIN      3'h3
`define PROG_MIN_US   3700
`define PROG_MAX_US   4500
`define CLK_MHZ       25
`define LOCK_RESET    6'h3f
`define ERASED_WORD   16'hffff

`define PTR_LOW_FUSE  16'h0000
`define PTR_LOCK      16'h0001
`define PTR_EXT_FUSE  16'h0002
`define PTR_HIGH_FUSE 16'h0003

`endif

//--- flash_sp_pkg.sv
package flash_sp_pkg;
	typedef enum logic [1:0] {
		OP_IDLE  = 2'b00,
		OP_ERASE = 2'b01,
		OP_WRITE = 2'b10,
		OP_LOCK  = 2'b11
	} op_e;
	typedef logic [15:0] word_t;
endpackage

//--- flash_sp.sv
`timescale 1ns/1ps
`include "flash_sp_regs.svh"
module flash_sp
	import flash_sp_pkg::*;
#(
	parameter int PROG_CYCLES = `PROG_MIN_US * `CLK_MHZ,
	parameter int WORDS       = 64
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        sys_reset_n,
	input  wire logic        eeprom_write_busy_flag,
	input  wire logic [7:0]  low_fuse_byte,
	input  wire logic [7:0]  high_fuse_byte,
	input  wire logic [7:0]  extended_fuse_byte,
	input  wire logic [5:0]  buf_rd_addr,
	output word_t            buf_rd_data,
	output logic             flash_erase,
	output logic             flash_program,
	output logic [6:0]       flash_page,
	output logic             rww_block,
	output logic             cpu_halt,
	output logic             spm_irq
);

	// control register fields
	logic        irq_enable;
	logic        read_section_reenable_bit;
	logic        lock_set_bit;
	logic        page_write_bit;
	logic        page_erase_bit;
	logic        command_enable_bit;
	logic        read_section_busy_flag;
	word_t       pointer;
	word_t       data_register_pair;
	logic [7:0]  readback;
	logic [5:0]  lock_bits;
	logic [2:0]  store_win;
	logic [2:0]  load_win;
	logic [31:0] op_count;
	op_e         op;
	word_t       buf_mem [WORDS];
	logic [WORDS-1:0] buf_valid;

	logic wr_acc;
	logic rd_setup;
	logic ctrl_wr;
	logic store_go;
	logic load_go;
	logic op_done;
	logic [3:0] cmd;

	function automatic logic [6:0] page_of(input word_t z);
		page_of = z[`PAGE_HI:`PAGE_LO];
	endfunction

	function automatic logic [5:0] word_of(input word_t z);
		word_of = z[`WORD_HI:`WORD_LO];
	endfunction

	// writes take effect at the access edge; reads are prepared in setup
	assign wr_acc   = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	// eeprom busy blocks control register writes, all but the interrupt enable bit
	assign ctrl_wr  = wr_acc & (paddr == `CTRL_OFS) & ~eeprom_write_busy_flag
		& (op == OP_IDLE);
	assign store_go = wr_acc & (paddr == `INSTR_OFS) & pwdata[`INSTR_STORE]
		& command_enable_bit & (store_win != 3'h0) & (op == OP_IDLE)
		& ~eeprom_write_busy_flag;
	assign load_go  = wr_acc & (paddr == `INSTR_OFS) & pwdata[`INSTR_LOAD]
		& command_enable_bit & lock_set_bit & (load_win != 3'h0)
		& (op == OP_IDLE) & ~eeprom_write_busy_flag;
	assign cmd      = {read_section_reenable_bit, lock_set_bit, page_write_bit,
		page_erase_bit};
	assign op_done  = (op != OP_IDLE) && (op_count == 32'd1);

	// apb answer: zero wait states, pready only in the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~(paddr inside {`CTRL_OFS, `PTR_OFS,
				`DATA_OFS, `INSTR_OFS, `RDBK_OFS, `STATUS_OFS});
		end
	end

	// read data mux, captured in setup so it is steady for the access edge
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h0;
		end else if (rd_setup) begin
			unique case (paddr)
				`CTRL_OFS:   prdata <= {24'h0, irq_enable, read_section_busy_flag,
					1'b0, read_section_reenable_bit, lock_set_bit,
					page_write_bit, page_erase_bit, command_enable_bit};
				`PTR_OFS:    prdata <= {16'h0, pointer};
				`DATA_OFS:   prdata <= {16'h0, data_register_pair};
				`RDBK_OFS:   prdata <= {24'h0, readback};
				`STATUS_OFS: prdata <= {18'h0, lock_bits, 5'h0, cpu_halt,
					(op != OP_IDLE), eeprom_write_busy_flag};
				default:     prdata <= 32'h0;
			endcase
		end
	end

	// pointer and data pair; only the pointer's page field is latched, into flash_page, at start of an op
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pointer            <= 16'h0;
			data_register_pair <= 16'h0;
		end else begin
			if (wr_acc && paddr == `PTR_OFS)
				pointer <= pwdata[15:0];
			if (wr_acc && paddr == `DATA_OFS)
				data_register_pair <= pwdata[15:0];
		end
	end

	// control bits; system reset clears them but never an operation in flight
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_enable                <= 1'b0;
			read_section_reenable_bit <= 1'b0;
			lock_set_bit              <= 1'b0;
			page_write_bit            <= 1'b0;
			page_erase_bit            <= 1'b0;
			command_enable_bit        <= 1'b0;
		end else if (!sys_reset_n && op == OP_IDLE) begin
			irq_enable                <= 1'b0;
			read_section_reenable_bit <= 1'b0;
			lock_set_bit              <= 1'b0;
			page_write_bit            <= 1'b0;
			page_erase_bit            <= 1'b0;
			command_enable_bit        <= 1'b0;
		end else if (op_done || load_go || (op == OP_IDLE && !store_go && !ctrl_wr
			&& command_enable_bit && store_win == 3'h1)) begin
			read_section_reenable_bit <= 1'b0;
			lock_set_bit              <= 1'b0;
			page_write_bit            <= 1'b0;
			page_erase_bit            <= 1'b0;
			command_enable_bit        <= 1'b0;
		end else if (store_go && op == OP_IDLE && !(cmd inside {4'h1, 4'h2, 4'h4})) begin
			read_section_reenable_bit <= 1'b0; // loads and reenable end at once
			lock_set_bit              <= 1'b0;
			page_write_bit            <= 1'b0;
			page_erase_bit            <= 1'b0;
			command_enable_bit        <= 1'b0;
		end else if (ctrl_wr) begin
			irq_enable                <= pwdata[`CTRL_IE];
			read_section_reenable_bit <= pwdata[`CTRL_REEN];
			lock_set_bit              <= pwdata[`CTRL_LOCK];
			page_write_bit            <= pwdata[`CTRL_WR];
			page_erase_bit            <= pwdata[`CTRL_ER];
			command_enable_bit        <= pwdata[`CTRL_EN];
		end else if (wr_acc && paddr == `CTRL_OFS) begin
			irq_enable <= pwdata[`CTRL_IE]; // interrupt enable stays writable
		end
	end

	// instruction windows opened by setting the enable bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			store_win <= 3'h0;
			load_win  <= 3'h0;
		end else if (ctrl_wr && pwdata[`CTRL_EN]) begin
			store_win <= `STORE_WIN;
			load_win  <= `LOAD_WIN;
		end else if (store_go || load_go) begin
			store_win <= 3'h0;
			load_win  <= 3'h0;
		end else begin
			if (store_win != 3'h0)
				store_win <= store_win - 3'h1;
			if (load_win != 3'h0)
				load_win <= load_win - 3'h1;
		end
	end

	// operation timer; only the power-on reset stops it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op         <= OP_IDLE;
			op_count   <= 32'h0;
			flash_page <= 7'h0;
		end else if (op_done) begin
			op       <= OP_IDLE;
			op_count <= 32'h0;
		end else if (op != OP_IDLE) begin
			op_count <= op_count - 32'd1;
		end else if (store_go) begin
			op_count   <= 32'(PROG_CYCLES);
			flash_page <= page_of(pointer);
			unique case (cmd)
				4'h1:    op <= OP_ERASE;
				4'h2:    op <= OP_WRITE;
				4'h4:    op <= OP_LOCK;
				default: op <= OP_IDLE;
			endcase
		end
	end

	// flash strobes, blocking and halting, all registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			flash_erase   <= 1'b0;
			flash_program <= 1'b0;
			rww_block     <= 1'b0;
			cpu_halt      <= 1'b0;
		end else if (op_done) begin
			flash_erase   <= 1'b0;
			flash_program <= 1'b0;
			rww_block     <= 1'b0;
			cpu_halt      <= 1'b0;
		end else if (store_go && (cmd == 4'h1 || cmd == 4'h2)) begin
			flash_erase   <= cmd == 4'h1;
			flash_program <= cmd == 4'h2;
			rww_block     <= 1'b1;
			cpu_halt      <= page_of(pointer) >= `NO_READ_WHILE_WRITE_AREA_PAGE;
		end else if (store_go && cmd == 4'h4) begin
			rww_block <= 1'b0;
		end
	end

	// busy flag: set with any erase/write, cleared only by reenable command
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			read_section_busy_flag <= 1'b0;
		end else if (store_go && (cmd == 4'h1 || cmd == 4'h2)) begin
			read_section_busy_flag <= 1'b1;
		end else if (store_go && cmd == 4'h8) begin
			read_section_busy_flag <= 1'b0;
		end
	end

	// lock bits live here; zeros in data program them, never unprogram
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_bits <= `LOCK_RESET;
		end else if (store_go && cmd == 4'h4) begin
			lock_bits <= lock_bits & data_register_pair[5:0];
		end
	end

	// fuse and lock readback; values already follow zero-means-programmed
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			readback <= 8'h0;
		end else if (load_go) begin
			unique case (pointer)
				`PTR_LOW_FUSE:  readback <= low_fuse_byte;
				`PTR_LOCK:      readback <= {2'b11, lock_bits};
				`PTR_EXT_FUSE:  readback <= extended_fuse_byte;
				`PTR_HIGH_FUSE: readback <= high_fuse_byte;
				default:        readback <= 8'hff;
			endcase
		end
	end

	// temporary buffer valid bits; storage itself needs no reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			buf_valid <= '0;
		end else if (!sys_reset_n || (op == OP_WRITE && op_done)) begin
			buf_valid <= '0;
		end else if (store_go && cmd == 4'h8) begin
			buf_valid <= '0;
		end else if (eeprom_write_busy_flag && op == OP_IDLE) begin
			buf_valid <= '0;
		end else if (store_go && cmd == 4'h0) begin
			buf_valid[word_of(pointer)] <= 1'b1;
		end
	end

	// one word per load at any word address; reloading simply overwrites
	always_ff @(posedge pclk) begin
		if (store_go && cmd == 4'h0)
			buf_mem[word_of(pointer)] <= data_register_pair;
	end

	// flash-side buffer read; unloaded words read as erased
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			buf_rd_data <= `ERASED_WORD;
		else
			buf_rd_data <= buf_valid[buf_rd_addr] ? buf_mem[buf_rd_addr] : `ERASED_WORD;
	end

	// level interrupt while enable bit is clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			spm_irq <= 1'b0;
		else
			spm_irq <= irq_enable & ~command_enable_bit;
	end

	// checks
	logic [31:0] op_age;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			op_age <= 32'h0;
		else if (op == OP_IDLE)
			op_age <= 32'h0;
		else
			op_age <= op_age + 32'd1;
	end

	irq_level_a: assert property (@(posedge pclk) disable iff (!presetn)
		##1 spm_irq == $past(irq_enable & ~command_enable_bit))
		else $error("interrupt level does not follow enable bit");
	enable_held_a: assert property (@(posedge pclk) disable iff (!presetn)
		(op != OP_IDLE) |-> command_enable_bit)
		else $error("enable bit dropped during operation");
	op_length_a: assert property (@(posedge pclk) disable iff (!presetn)
		op_done |-> op_age == 32'(PROG_CYCLES - 1))
		else $error("operation length wrong");
	busy_block_a: assert property (@(posedge pclk) disable iff (!presetn)
		(store_go && cmd == 4'h1) |=> rww_block && read_section_busy_flag && flash_erase)
		else $error("erase did not block read area");
	lock_free_a: assert property (@(posedge pclk) disable iff (!presetn)
		(op == OP_LOCK) |-> !rww_block && !cpu_halt)
		else $error("lock programming blocked flash");
	window_close_a: assert property (@(posedge pclk) disable iff (!presetn)
		(store_win == 3'h0 && op == OP_IDLE && $past(store_win) == 3'h0
			&& $past(op) == OP_IDLE && !$past(ctrl_wr)) |-> !command_enable_bit)
		else $error("enable bit survived expired window");
	eeprom_refuse_a: assert property (@(posedge pclk) disable iff (!presetn)
		eeprom_write_busy_flag |-> !store_go && !load_go && !ctrl_wr)
		else $error("command taken during eeprom write");
	write_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(op == OP_WRITE && op_done) |=> buf_valid == '0)
		else $error("buffer kept after page write");
	reenable_a: assert property (@(posedge pclk) disable iff (!presetn)
		(store_go && cmd == 4'h8) |=> !read_section_busy_flag && buf_valid == '0)
		else $error("reenable did not clear busy flag");
	halt_page_a: assert property (@(posedge pclk) disable iff (!presetn)
		(store_go && cmd == 4'h2) |=> cpu_halt == ($past(pointer[`PAGE_HI:`PAGE_LO]) >= `NO_READ_WHILE_WRITE_AREA_PAGE))
		else $error("halt does not match target page");

	// bus answer and latched fields; these catch a broken mux or latch, not just wiring
	apb_ready_a: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && !penable) |=> pready)
		else $error("no ready in access phase");
	apb_single_a: assert property (@(posedge pclk) disable iff (!presetn)
		pready |-> $past(psel && !penable))
		else $error("ready outside access phase");
	page_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
		(store_go && (cmd == 4'h1 || cmd == 4'h2))
			|=> flash_page == $past(pointer[`PAGE_HI:`PAGE_LO]))
		else $error("page select not latched");
	lock_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		(lock_bits & ~$past(lock_bits)) == 6'h0)
		else $error("lock bit unprogrammed");
	lock_prog_a: assert property (@(posedge pclk) disable iff (!presetn)
		(store_go && cmd == 4'h4)
			|=> lock_bits == ($past(lock_bits) & $past(data_register_pair[5:0])))
		else $error("lock bits not programmed from data");
	fuse_high_a: assert property (@(posedge pclk) disable iff (!presetn)
		(load_go && pointer == `PTR_HIGH_FUSE) |=> readback == $past(high_fuse_byte))
		else $error("high fuse byte not returned");
	reset_keep_a: assert property (@(posedge pclk) disable iff (!presetn)
		(!sys_reset_n && op != OP_IDLE && !op_done) |=> op != OP_IDLE)
		else $error("system reset aborted operation");
	eeprom_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		(eeprom_write_busy_flag && op == OP_IDLE) |=> buf_valid == '0)
		else $error("buffer kept during eeprom write");
	buf_load_a: assert property (@(posedge pclk) disable iff (!presetn)
		(store_go && cmd == 4'h0 && sys_reset_n)
			|=> buf_valid[$past(pointer[`WORD_HI:`WORD_LO])]
			&& buf_mem[$past(pointer[`WORD_HI:`WORD_LO])] == $past(data_register_pair))
		else $error("buffer word not loaded");

endmodule // flash_sp

//--- cpu_boot_model.sv
`timescale 1ns/1ps
`include "flash_sp_regs.svh"
module cpu_boot_model (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	logic [31:0] r;
	logic        e;
	// bus idle from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	// one transfer; stays selected so a next setup may follow at once
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// the answer is taken at the very rising edge that samples pready high
		@(posedge pclk);
		while (!pready)
			@(posedge pclk);
		r = prdata;
		e = pslverr;
	endtask
	// release: address and data turn over so no stale value lingers
	task automatic rel();
		psel    <= 1'b0;
		penable <= 1'b0;
		paddr   <= ~paddr;
		pwdata  <= ~pwdata;
		@(posedge pclk);
	endtask
	// timed sequence: control write, then the instruction two edges later
	task automatic spm(input logic [7:0] c, input logic [15:0] p, d, input logic [1:0] i);
		xfer(1'b1, `PTR_OFS, {16'h0, p});
		xfer(1'b1, `DATA_OFS, {16'h0, d});
		xfer(1'b1, `CTRL_OFS, {24'h0, c});
		xfer(1'b1, `INSTR_OFS, {30'h0, i});
		rel();
	endtask
	// poll eeprom busy, then the enable bit, before the next command
	task automatic wait_idle();
		r = 32'h1;
		while (r[0]) begin
			xfer(1'b0, `STATUS_OFS, 32'h0);
			if (!r[0]) xfer(1'b0, `CTRL_OFS, 32'h0);
		end
		rel();
	endtask
endmodule // cpu_boot_model

//--- flash_self_programming_tb_top.sv
`timescale 1ns/1ps
`include "flash_sp_regs.svh"
module flash_self_programming_tb_top;
	import flash_sp_pkg::*;
	localparam int PC = 20;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        sys_reset_n = 1'b1;
	logic        eeprom_write_busy_flag = 1'b0;
	logic [7:0]  low_fuse_byte = 8'hff;
	logic [7:0]  high_fuse_byte = 8'hff;
	logic [7:0]  extended_fuse_byte = 8'hff;
	logic [5:0]  buf_rd_addr = 6'h0;
	logic        psel, penable, pwrite, pready, pslverr;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata;
	word_t       buf_rd_data;
	logic        flash_erase, flash_program, rww_block, cpu_halt, spm_irq;
	logic [6:0]  flash_page;
	logic [31:0] rnd = 32'h5349cc4f;
	logic [5:0]  locks;
	logic [5:0]  idx [4] = '{6'd37, 6'd2, 6'd63, 6'd0};
	word_t       wd [4];
	int          bad_count = 0;
	int          n_tests = 0;
	int          op_len = 0;
	int          len0 = 0;

	flash_sp #(.PROG_CYCLES(PC)) flash_sp_inst (.pclk, .presetn, .psel, .penable, .pwrite,
		.paddr, .pwdata, .prdata, .pready, .pslverr, .sys_reset_n, .eeprom_write_busy_flag,
		.low_fuse_byte, .high_fuse_byte, .extended_fuse_byte, .buf_rd_addr, .buf_rd_data,
		.flash_erase, .flash_program, .flash_page, .rww_block, .cpu_halt, .spm_irq);
	cpu_boot_model cpu (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr);

	always #20 pclk = ~pclk;
	// program time as seen at the flash side
	always @(posedge pclk) if (flash_erase || flash_program) op_len <= op_len + 1;

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic logic [7:0] fuse_exp(input int p);
		case (p)
			0: return low_fuse_byte;
			1: return {2'b11, locks};
			2: return extended_fuse_byte;
			default: return high_fuse_byte;
		endcase
	endfunction
	task automatic check(input string nm, input logic [31:0] ex, input logic [31:0] got);
		n_tests++;
		if (got !== ex) begin
			bad_count++;
			$display("Error %s expected %h seen %h", nm, ex, got);
		end
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] mk, ex, input string nm);
		cpu.xfer(1'b0, a, 32'h0);
		cpu.rel();
		check(nm, ex, cpu.r & mk);
	endtask
	// buffer read port has one cycle of latency
	task automatic buf_chk(input logic [5:0] a, input word_t ex);
		buf_rd_addr <= a;
		repeat (2) @(posedge pclk);
		@(negedge pclk);
		check("buffer word", {16'h0, ex}, {16'h0, buf_rd_data});
		@(posedge pclk);
	endtask
	// bounded wait for the flash side to go quiet
	task automatic wait_op();
		int k;
		k = 0;
		while ((flash_erase || flash_program) && k < 200) begin
			@(posedge pclk);
			k++;
		end
		@(posedge pclk);
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask

	// watchdog: the sequence needs a few hundred cycles
	initial begin
		repeat (20000) @(posedge pclk);
		bad_count++;
		complete_run();
	end

	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		low_fuse_byte <= rnd[7:0];
		high_fuse_byte <= rnd[15:8];
		extended_fuse_byte <= rnd[23:16];
		@(posedge pclk);
		rc(`CTRL_OFS, 32'hff, 32'h0, "ctrl reset");
		rc(`STATUS_OFS, 32'h3f00, 32'h3f00, "lock reset");
		cpu.xfer(1'b0, 8'h20, 32'h0);
		cpu.rel();
		check("unmapped", 32'h1, {31'h0, cpu.e});
		$display("reset test done");
		// buffer filled out of order, boundary words included
		foreach (wd[j]) begin
			rnd = lfsr(rnd);
			wd[j] = rnd[15:0];
			cpu.spm(8'h01, {9'h0, idx[j], 1'b0}, wd[j], 2'b01);
		end
		foreach (wd[j]) buf_chk(idx[j], wd[j]);
		buf_chk(6'd10, 16'hffff);
		$display("load test done");
		// erase with junk outside the page field and the interrupt enabled
		len0 = op_len;
		cpu.spm(8'h83, {2'b11, 7'h6f, 7'h2b}, rnd[31:16], 2'b01);
		@(negedge pclk);
		check("erase", 32'h1, 32'(flash_erase));
		check("page", 32'h6f, 32'(flash_page));
		check("block", 32'h1, 32'(rww_block));
		check("halt", 32'h0, 32'(cpu_halt));
		check("irq busy", 32'h0, 32'(spm_irq));
		@(posedge pclk);
		rc(`CTRL_OFS, 32'hc3, 32'hc3, "ctrl busy");
		wait_op();
		check("erase time", PC, op_len - len0);
		rc(`CTRL_OFS, 32'h43, 32'h40, "ctrl done");
		check("irq idle", 32'h1, 32'(spm_irq));
		len0 = op_len;
		cpu.spm(8'h05, {2'b00, 7'h6f, 7'h00}, 16'h0, 2'b01);
		@(negedge pclk);
		check("write", 32'h1, 32'(flash_program));
		check("write page", 32'h6f, 32'(flash_page));
		@(posedge pclk);
		wait_op();
		check("write time", PC, op_len - len0);
		buf_chk(6'd37, 16'hffff);
		cpu.spm(8'h11, 16'h0, 16'h0, 2'b01);
		rc(`CTRL_OFS, 32'h40, 32'h0, "busy clear");
		check("block off", 32'h0, 32'(rww_block));
		$display("erase write test done");
		// system reset during an erase of the lowest halting page
		cpu.spm(8'h01, 16'h0012, 16'h1234, 2'b01);
		len0 = op_len;
		cpu.spm(8'h03, {2'b00, 7'h70, 7'h00}, 16'h0, 2'b01);
		sys_reset_n <= 1'b0;
		repeat (2) @(posedge pclk);
		sys_reset_n <= 1'b1;
		@(negedge pclk);
		check("halt", 32'h1, 32'(cpu_halt));
		check("erase kept", 32'h1, 32'(flash_erase));
		@(posedge pclk);
		buf_chk(6'd9, 16'hffff);
		wait_op();
		check("erase after reset", PC, op_len - len0);
		// write to the same halting page; only the irq enable may change meanwhile
		cpu.spm(8'h05, {2'b00, 7'h70, 7'h00}, 16'h0, 2'b01);
		@(negedge pclk);
		check("write halt", 32'h1, 32'(cpu_halt));
		@(posedge pclk);
		cpu.xfer(1'b1, `CTRL_OFS, 32'h80);
		cpu.rel();
		rc(`CTRL_OFS, 32'h8f, 32'h85, "ctrl in op");
		check("irq in op", 32'h0, 32'(spm_irq));
		wait_op();
		check("irq done", 32'h1, 32'(spm_irq));
		$display("reset during erase test done");
		// lock programming: zero data bits program lock bits
		rnd = lfsr(rnd);
		locks = rnd[5:0];
		cpu.spm(8'h09, 16'h0001, {8'h0, 2'b11, locks}, 2'b01);
		@(negedge pclk);
		check("lock block", 32'h0, {31'h0, rww_block | cpu_halt});
		@(posedge pclk);
		cpu.wait_idle();
		rc(`STATUS_OFS, 32'h3f00, {18'h0, locks, 8'h0}, "locks");
		for (int p = 0; p < 4; p++) begin
			cpu.spm(8'h09, p[15:0], 16'h0, 2'b10);
			rc(`RDBK_OFS, 32'hff, {24'h0, fuse_exp(p)}, "readback");
			rc(`CTRL_OFS, 32'h09, 32'h0, "auto clear");
		end
		$display("lock test done");
		// store too late after the control write
		cpu.xfer(1'b1, `CTRL_OFS, 32'h03);
		cpu.rel();
		repeat (5) @(posedge pclk);
		cpu.xfer(1'b1, `INSTR_OFS, 32'h1);
		cpu.rel();
		@(negedge pclk);
		check("late store", 32'h0, 32'(flash_erase));
		@(posedge pclk);
		rc(`CTRL_OFS, 32'h03, 32'h0, "expired");
		$display("window test done");
		// eeprom write while loading, then a command refused
		cpu.spm(8'h01, 16'h0028, 16'h5a5a, 2'b01);
		eeprom_write_busy_flag <= 1'b1;
		repeat (2) @(posedge pclk);
		buf_chk(6'd20, 16'hffff);
		cpu.spm(8'h03, 16'h0280, 16'h0, 2'b01);
		@(negedge pclk);
		check("refused", 32'h0, 32'(flash_erase));
		@(posedge pclk);
		rc(`CTRL_OFS, 32'h01, 32'h0, "refused ctrl");
		rc(`STATUS_OFS, 32'h1, 32'h1, "eeprom flag");
		eeprom_write_busy_flag <= 1'b0;
		check("irq off", 32'h0, 32'(spm_irq));
		$display("eeprom test done");
		complete_run();
	end
endmodule // flash_self_programming_tb_top
